// >>> core/irq_arbiter_pkg.sv
// constants and types shared by the two-level interrupt arbiter
package irq_arbiter_pkg;

   localparam int unsigned SRC_COUNT = 8;
   localparam int unsigned IDX_W = 3;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned PORT_W = 8;
   localparam int unsigned PERIPH_COUNT = 6;

   // register offsets
   localparam logic [7:0] FLAG_ADDR = 8'h00;
   localparam logic [7:0] ENABLE_ADDR = 8'h04;
   localparam logic [7:0] PRIO_ADDR = 8'h08;
   localparam logic [7:0] GLOBAL_ADDR = 8'h0C;
   localparam logic [7:0] STATE_ADDR = 8'h10;
   localparam logic [7:0] PIN_CFG_ADDR = 8'hE4;

   // reset values
   localparam logic [7:0] FLAG_RESET = 8'h00;
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   localparam logic [7:0] PRIO_RESET = 8'h00;
   localparam logic GLOBAL_RESET = 1'b0;
   localparam logic [7:0] PIN_CFG_RESET = 8'h01;

   // external_irq_pin_config fields
   localparam int unsigned ONE_POL_BIT = 7;
   localparam int unsigned ONE_SEL_LSB = 4;
   localparam int unsigned ZERO_POL_BIT = 3;
   localparam int unsigned ZERO_SEL_LSB = 0;

   // global and state register fields
   localparam int unsigned GLOBAL_EN_BIT = 0;
   localparam int unsigned ST_HIGH_BIT = 0;
   localparam int unsigned ST_LOW_BIT = 1;
   localparam int unsigned ST_CALL_BIT = 2;
   localparam int unsigned ST_HOLD_BIT = 3;
   localparam int unsigned ST_VEC_LSB = 4;

   // source slots; lower index wins a tie inside one level
   localparam int unsigned EXT_ZERO_SRC = 0;
   localparam int unsigned EXT_ONE_SRC = 1;
   localparam int unsigned PERIPH_LSB = 2;

   // timing in system clock cycles
   localparam int unsigned DETECT_CYCLES = 1;
   localparam int unsigned LONG_CALL_CYCLES = 5;
   localparam logic [2:0] CALL_LAST = 3'(LONG_CALL_CYCLES - 1);

   typedef enum logic {ST_IDLE, ST_CALL} arb_state_t;

endpackage : irq_arbiter_pkg

// >>> core/pin_sync.sv
// two-stage synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
   parameter int unsigned WIDTH = 8
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage_one;

   // first stage feeds only the second stage
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         stage_one <= '0;
         sync_out <= '0;
      end
      else
      begin
         stage_one <= async_in;
         sync_out <= stage_one;
      end
   end

endmodule : pin_sync

// >>> core/prio_pick.sv
// picks the winning request: high level first, then lowest index
`timescale 1ns/1ps
module prio_pick (
   input wire logic [irq_arbiter_pkg::SRC_COUNT-1:0] req,
   input wire logic [irq_arbiter_pkg::SRC_COUNT-1:0] prio,
   output logic found,
   output logic is_high,
   output logic [irq_arbiter_pkg::IDX_W-1:0] index
);

   localparam int unsigned N = irq_arbiter_pkg::SRC_COUNT;

   logic [N-1:0] high_req;
   logic [N-1:0] pool;

   // lowest set bit of a vector
   function automatic logic [irq_arbiter_pkg::IDX_W-1:0] first_set(input logic [N-1:0] v);
      logic [irq_arbiter_pkg::IDX_W-1:0] r;
      r = '0;
      for (int i = N - 1; i >= 0; i--)
      begin
         if (v[i])
            r = irq_arbiter_pkg::IDX_W'(i);
      end
      return r;
   endfunction : first_set

   assign high_req = req & prio;
   assign is_high = |high_req;
   assign found = |req;
   assign pool = is_high ? high_req : req;
   assign index = first_set(pool);

endmodule : prio_pick

// >>> core/irq_arbiter.sv
// two-level interrupt arbiter with call sequencing and external pin inputs
//
// What this block does
// - every source has its own priority bit choosing low or high level
// - high request preempts a low routine; a high routine is never preempted
// - after a preempting high routine returns, the low routine resumes
// - all priority bits reset to low
// - higher level served first; ties broken by fixed source order
// - pending requests sampled and priority decoded every cycle
// - fastest response: detect, one instruction, five-cycle long call
// - after return_from_interrupt one more instruction runs before the next call
// - worst case nineteen cycles: detect, return, divide, long call
// - equal or lower request waits for return plus one instruction
// - config bit 7 sets external_irq_one polarity, 1 active high
// - config bits 6:4 pick the port 0 pin for external_irq_one
// - config bit 3 sets external input zero polarity, 1 active high
// - config bits 2:0 pick the port 0 pin for external input zero
// - external inputs only observe port pins, never drive them
// - a flag starts a call only with its own and the global enable set; irq ignores the global enable
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module irq_arbiter (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [irq_arbiter_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [irq_arbiter_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [irq_arbiter_pkg::DATA_W-1:0] reg_rdata,
   input wire logic [irq_arbiter_pkg::PORT_W-1:0] port0_pins,
   input wire logic [irq_arbiter_pkg::PERIPH_COUNT-1:0] periph_event,
   input wire logic instr_done,
   input wire logic return_from_interrupt_done,
   output logic call_busy,
   output logic [irq_arbiter_pkg::IDX_W-1:0] call_vector,
   output logic in_service_high,
   output logic in_service_low,
   output logic irq
);

   localparam int unsigned N = irq_arbiter_pkg::SRC_COUNT;
   localparam int unsigned W = irq_arbiter_pkg::IDX_W;

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
      return addr == offset;
   endfunction : hit

   // register bus decode
   logic wr_flag;
   logic wr_enable;
   logic wr_prio;
   logic wr_global;
   logic wr_cfg;
   assign wr_flag = reg_wr && hit(reg_addr, irq_arbiter_pkg::FLAG_ADDR);
   assign wr_enable = reg_wr && hit(reg_addr, irq_arbiter_pkg::ENABLE_ADDR);
   assign wr_prio = reg_wr && hit(reg_addr, irq_arbiter_pkg::PRIO_ADDR);
   assign wr_global = reg_wr && hit(reg_addr, irq_arbiter_pkg::GLOBAL_ADDR);
   assign wr_cfg = reg_wr && hit(reg_addr, irq_arbiter_pkg::PIN_CFG_ADDR);

   logic [N-1:0] flag;
   logic [N-1:0] enable;
   logic [N-1:0] prio;
   logic global_en;
   logic [7:0] pin_cfg;

   // external pins: observe only, no drive path exists
   logic [irq_arbiter_pkg::PORT_W-1:0] pins_sync;
   pin_sync #(.WIDTH(irq_arbiter_pkg::PORT_W)) u_pin_sync (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .async_in(port0_pins),
      .sync_out(pins_sync)
   );

   logic [W-1:0] ext_one_pin_select;
   logic [W-1:0] ext_zero_pin_select;
   logic ext_irq_one_polarity;
   logic ext_irq_zero_polarity;
   assign ext_irq_one_polarity = pin_cfg[irq_arbiter_pkg::ONE_POL_BIT];
   assign ext_one_pin_select = pin_cfg[irq_arbiter_pkg::ONE_SEL_LSB +: W];
   assign ext_irq_zero_polarity = pin_cfg[irq_arbiter_pkg::ZERO_POL_BIT];
   assign ext_zero_pin_select = pin_cfg[irq_arbiter_pkg::ZERO_SEL_LSB +: W];

   // polarity applied after synchronising; active level is true
   logic external_irq_one;
   logic ext_irq_zero;
   assign external_irq_one = pins_sync[ext_one_pin_select] == ext_irq_one_polarity;
   assign ext_irq_zero = pins_sync[ext_zero_pin_select] == ext_irq_zero_polarity;

   // edge sensing, so a held level posts one flag per assertion
   logic ext_one_prev;
   logic ext_zero_prev;
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         // start as already active: synced pins read low after reset, no false edge
         ext_one_prev <= 1'b1;
         ext_zero_prev <= 1'b1;
      end
      else
      begin
         ext_one_prev <= external_irq_one;
         ext_zero_prev <= ext_irq_zero;
      end
   end

   logic [N-1:0] flag_set;
   logic [N-1:0] next_flag;
   assign flag_set = {periph_event, external_irq_one & ~ext_one_prev,
                      ext_irq_zero & ~ext_zero_prev};
   // a new event beats a write-one clear in the same cycle
   assign next_flag = (flag & ~(wr_flag ? reg_wdata : 8'h00)) | flag_set;

   // configuration registers
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         flag <= irq_arbiter_pkg::FLAG_RESET;
         enable <= irq_arbiter_pkg::ENABLE_RESET;
         prio <= irq_arbiter_pkg::PRIO_RESET;
         global_en <= irq_arbiter_pkg::GLOBAL_RESET;
         pin_cfg <= irq_arbiter_pkg::PIN_CFG_RESET;
      end
      else
      begin
         flag <= next_flag;
         if (wr_enable)
            enable <= reg_wdata;
         if (wr_prio)
            prio <= reg_wdata;
         if (wr_global)
            global_en <= reg_wdata[irq_arbiter_pkg::GLOBAL_EN_BIT];
         if (wr_cfg)
            pin_cfg <= reg_wdata;
      end
   end

   // requests and arbitration, re-evaluated every cycle
   logic [N-1:0] req;
   assign req = flag & enable & {N{global_en}};

   logic pick_found;
   logic pick_high;
   logic [W-1:0] pick_idx;
   prio_pick u_prio_pick (
      .req(req),
      .prio(prio),
      .found(pick_found),
      .is_high(pick_high),
      .index(pick_idx)
   );

   irq_arbiter_pkg::arb_state_t state;
   irq_arbiter_pkg::arb_state_t next_state;
   logic [2:0] call_count;
   logic hi_active;
   logic lo_active;
   logic hold_one;

   // high preempts low; nothing preempts high; same level waits
   logic level_ok;
   assign level_ok = pick_high ? !hi_active : (!hi_active && !lo_active);

   // calls start only at an instruction boundary, so a return is always followed by
   // at least one instruction before the next call
   logic start_call;
   assign start_call = (state == irq_arbiter_pkg::ST_IDLE) && instr_done
                       && pick_found && level_ok;

   logic call_end;
   assign call_end = (state == irq_arbiter_pkg::ST_CALL)
                     && (call_count == irq_arbiter_pkg::CALL_LAST);

   always_comb
   begin
      case (state)
         irq_arbiter_pkg::ST_IDLE: next_state = start_call ? irq_arbiter_pkg::ST_CALL
                                                           : irq_arbiter_pkg::ST_IDLE;
         irq_arbiter_pkg::ST_CALL: next_state = call_end ? irq_arbiter_pkg::ST_IDLE
                                                         : irq_arbiter_pkg::ST_CALL;
         default: next_state = irq_arbiter_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         state <= irq_arbiter_pkg::ST_IDLE;
         call_count <= 3'h0;
         call_busy <= 1'b0;
         call_vector <= '0;
      end
      else
      begin
         state <= next_state;
         call_count <= (next_state == irq_arbiter_pkg::ST_CALL && !start_call)
                       ? call_count + 3'h1 : 3'h0;
         call_busy <= next_state == irq_arbiter_pkg::ST_CALL;
         if (start_call)
            call_vector <= pick_idx;
      end
   end

   // in-service levels; a return retires the most recent level first
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         hi_active <= 1'b0;
         lo_active <= 1'b0;
         hold_one <= 1'b0;
      end
      else
      begin
         if (start_call && pick_high)
            hi_active <= 1'b1;
         else if (return_from_interrupt_done && hi_active)
            hi_active <= 1'b0;
         if (start_call && !pick_high)
            lo_active <= 1'b1;
         else if (return_from_interrupt_done && !hi_active)
            lo_active <= 1'b0;
         if (return_from_interrupt_done)
            hold_one <= 1'b1;
         else if (instr_done)
            hold_one <= 1'b0;
      end
   end

   assign in_service_high = hi_active;
   assign in_service_low = lo_active;

   // interrupt output and read port
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         irq <= 1'b0;
      else
         irq <= |(next_flag & enable);
   end

   logic [7:0] state_word;
   logic [7:0] read_mux;
   assign state_word = {1'b0, call_vector, hold_one, call_busy, lo_active, hi_active};
   assign read_mux = hit(reg_addr, irq_arbiter_pkg::FLAG_ADDR) ? flag
                   : hit(reg_addr, irq_arbiter_pkg::ENABLE_ADDR) ? enable
                   : hit(reg_addr, irq_arbiter_pkg::PRIO_ADDR) ? prio
                   : hit(reg_addr, irq_arbiter_pkg::GLOBAL_ADDR) ? {7'h00, global_en}
                   : hit(reg_addr, irq_arbiter_pkg::STATE_ADDR) ? state_word
                   : hit(reg_addr, irq_arbiter_pkg::PIN_CFG_ADDR) ? pin_cfg
                   : 8'h00;

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         reg_rdata <= 8'h00;
      else
         reg_rdata <= reg_rd ? read_mux : 8'h00;
   end

   // checks
   default clocking chk_clk @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   logic [N-1:0] lower_mask;
   assign lower_mask = 8'((9'h001 << pick_idx) - 9'h001);

   prio_reset_a: assert property ($fell(sys_rst) |-> prio == 8'h00)
      else $error("priority bits not low after reset");

   call_len_a: assert property ($rose(call_busy) |-> call_busy [*5] ##1 !call_busy)
      else $error("long call not five cycles");

   high_locked_a: assert property (hi_active |-> !start_call)
      else $error("high routine was preempted");

   preempt_a: assert property (
      state == irq_arbiter_pkg::ST_IDLE && instr_done && !hold_one && pick_high
      && lo_active && !hi_active |=> call_busy && hi_active)
      else $error("high request failed to preempt low routine");

   resume_low_a: assert property (return_from_interrupt_done && hi_active && lo_active |=> !hi_active && lo_active)
      else $error("low routine lost after high return");

   one_instr_a: assert property (hold_one && instr_done && pick_found && level_ok
      && state == irq_arbiter_pkg::ST_IDLE |=> call_busy)
      else $error("call not made after one instruction past return");

   enable_gate_a: assert property (start_call |-> global_en && flag[pick_idx] && enable[pick_idx])
      else $error("call without enable");

   tie_order_a: assert property (start_call |-> ((req & (pick_high ? prio : ~prio)) & lower_mask) == 8'h00)
      else $error("fixed order violated");

   level_order_a: assert property (start_call && !pick_high |-> (req & prio) == 8'h00)
      else $error("low served ahead of high");

   equal_wait_a: assert property (lo_active && start_call |-> pick_high)
      else $error("equal level request not held");

   ext_zero_a: assert property ($rose(ext_irq_zero) |=> flag[irq_arbiter_pkg::EXT_ZERO_SRC])
      else $error("external zero edge not flagged");

   irq_out_a: assert property (|(flag & enable) |-> ##[0:1] irq)
      else $error("interrupt output missing");

   hold_set_a: assert property (return_from_interrupt_done |=> hold_one)
      else $error("return not tracked");

   quiet_start_a: assert property ($fell(sys_rst)
      |=> !flag[irq_arbiter_pkg::EXT_ZERO_SRC] && !flag[irq_arbiter_pkg::EXT_ONE_SRC])
      else $error("external flag raised by reset release");

   ext_one_a: assert property ($rose(external_irq_one)
      |=> flag[irq_arbiter_pkg::EXT_ONE_SRC])
      else $error("external one edge not flagged");

   global_off_a: assert property (!global_en |-> !start_call)
      else $error("call with global enable off");

   prio_write_a: assert property (wr_prio |=> prio == $past(reg_wdata))
      else $error("priority write lost");

   cfg_write_a: assert property (wr_cfg |=> pin_cfg == $past(reg_wdata))
      else $error("pin config write lost");

   call_vector_a: assert property (start_call |=> call_vector == $past(pick_idx))
      else $error("call vector not the winner");

   set_wins_a: assert property (|flag_set |=> (flag & $past(flag_set)) == $past(flag_set))
      else $error("event lost against clear");

   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside read cycle");

   preempt_c: cover property (lo_active && start_call);
   return_from_interrupt_pending_c: cover property (return_from_interrupt_done && pick_found ##1 instr_done ##1 call_busy);
   ext_one_c: cover property ($rose(flag[irq_arbiter_pkg::EXT_ONE_SRC]));
   tie_c: cover property (start_call && $countones(req) > 1);
   ext_zero_c: cover property ($rose(flag[irq_arbiter_pkg::EXT_ZERO_SRC]));

endmodule : irq_arbiter

// >>> verification/core_model.sv
// core sequencer model: instruction stream, long instructions and returns
`timescale 1ns/1ps
module core_model (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic run,
   input wire logic [3:0] instr_len,
   input wire logic ret_req,
   input wire logic call_busy,
   output logic instr_done,
   output logic return_from_interrupt_done
);
   logic [3:0] cnt;
   logic in_ret;
   logic ret_pend;
   logic [3:0] last;
   logic step;
   // the core stalls while the long call runs
   assign step = run && !call_busy;
   assign last = in_ret ? 4'h4 : instr_len - 4'h1;
   assign instr_done = step && !in_ret && cnt == last;
   assign return_from_interrupt_done = step && in_ret && cnt == last;
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         cnt <= 4'h0;
         in_ret <= 1'b0;
         ret_pend <= 1'b0;
      end
      else if (step && cnt == last)
      begin
         cnt <= 4'h0;
         in_ret <= ret_pend | ret_req;
         ret_pend <= 1'b0;
      end
      else
      begin
         if (step)
            cnt <= cnt + 4'h1;
         ret_pend <= ret_pend | ret_req;
      end
   end
endmodule : core_model

// >>> verification/tb_irq_arbiter.sv
// self-checking bench for the two-level interrupt arbiter
`timescale 1ns/1ps
module tb_irq_arbiter;
   localparam int LIMIT = 20000;
   localparam logic [7:0] FLG = irq_arbiter_pkg::FLAG_ADDR;
   localparam logic [7:0] ENA = irq_arbiter_pkg::ENABLE_ADDR;
   localparam logic [7:0] PRI = irq_arbiter_pkg::PRIO_ADDR;
   localparam logic [7:0] PIN = irq_arbiter_pkg::PIN_CFG_ADDR;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic [7:0] port0_pins = 8'hFF;
   logic [5:0] periph_event = 6'h00;
   logic instr_done, return_from_interrupt_done, call_busy, in_service_high, in_service_low, irq;
   logic [2:0] call_vector;
   logic run = 1'b0;
   logic [3:0] instr_len = 4'h1;
   logic ret_req = 1'b0;
   int num_errors = 0;
   int checks_done = 0;
   int cycles = 0;
   irq_arbiter DUT (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .port0_pins, .periph_event, .instr_done, .return_from_interrupt_done, .call_busy, .call_vector,
      .in_service_high, .in_service_low, .irq);
   core_model CORE (.sys_clk, .sys_rst, .run, .instr_len, .ret_req, .call_busy, .instr_done,
      .return_from_interrupt_done);
   initial
   begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test
   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         num_errors++;
         end_of_test();
      end
   end
   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input string name, input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      check(name, exp, reg_rdata);
   endtask : rd
   task automatic ev(input logic [5:0] m);
      @(posedge sys_clk);
      periph_event <= m;
      @(posedge sys_clk);
      periph_event <= 6'h00;
   endtask : ev
   // n counts cycles from the event or return cycle to the first busy cycle
   task automatic wait_call(input int exp_n, input logic [2:0] vec);
      int n;
      int m;
      n = 1;
      m = 0;
      @(negedge sys_clk);
      while (call_busy !== 1'b1 && n < 40)
      begin
         @(negedge sys_clk);
         n++;
      end
      if (exp_n != 0)
         check("response cycles", 8'(exp_n), 8'(n));
      check("call vector", {5'h00, vec}, {5'h00, call_vector});
      while (call_busy === 1'b1 && m < 20)
      begin
         @(negedge sys_clk);
         m++;
      end
      check("call length", 8'h05, 8'(m));
   endtask : wait_call
   task automatic no_call(input int n);
      logic seen;
      seen = 1'b0;
      repeat (n)
      begin
         @(negedge sys_clk);
         seen = seen | call_busy;
      end
      check("no call", 8'h00, {7'h00, seen});
   endtask : no_call
   task automatic do_return();
      int k;
      k = 0;
      @(posedge sys_clk);
      ret_req <= 1'b1;
      @(posedge sys_clk);
      ret_req <= 1'b0;
      @(negedge sys_clk);
      while (return_from_interrupt_done !== 1'b1 && k < 40)
      begin
         @(negedge sys_clk);
         k++;
      end
   endtask : do_return
   task automatic srv(input logic [5:0] m, input logic [7:0] p, input logic [2:0] v, input int n);
      wr(PRI, p);
      wr(FLG, 8'hFF);
      run <= (n != 0);
      ev(m);
      run <= 1'b1;
      wait_call(n, v);
      wr(FLG, 8'hFF);
      do_return();
      @(posedge sys_clk);
      run <= 1'b0;
      @(negedge sys_clk);
      check("retired", 8'h00, {6'h00, in_service_high, in_service_low});
   endtask : srv
   initial
   begin
      logic [7:0] cfg;
      logic pol;
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd("flags", FLG, 8'h00);
      rd("enable", ENA, 8'h00);
      rd("priority", PRI, 8'h00);
      rd("global", irq_arbiter_pkg::GLOBAL_ADDR, 8'h00);
      rd("state", irq_arbiter_pkg::STATE_ADDR, 8'h00);
      rd("pin config", PIN, 8'h01);
      rd("unmapped", 8'h20, 8'h00);
      // global enable off: flag and own enable alone must not call
      wr(ENA, 8'h04);
      ev(6'h01);
      run <= 1'b1;
      no_call(20);
      check("irq", 8'h01, {7'h00, irq});
      wr(irq_arbiter_pkg::GLOBAL_ADDR, 8'h01);
      wait_call(0, 3'h2);
      wr(FLG, 8'hFF);
      do_return();
      @(posedge sys_clk);
      run <= 1'b0;
      wr(ENA, 8'hFC);
      srv(6'h01, 8'h00, 3'h2, 2);
      srv(6'h0A, 8'h00, 3'h3, 0);
      srv(6'h0A, 8'h20, 3'h5, 0);
      srv(6'h30, 8'hC0, 3'h6, 0);
      // nesting: low, then high preempts, then high is not preempted
      wr(PRI, 8'h18);
      wr(FLG, 8'hFF);
      ev(6'h01);
      run <= 1'b1;
      wait_call(0, 3'h2);
      wr(FLG, 8'h04);
      ev(6'h02);
      wait_call(0, 3'h3);
      check("nested", 8'h03, {6'h00, in_service_high, in_service_low});
      wr(FLG, 8'h08);
      ev(6'h0C);
      no_call(20);
      do_return();
      wait_call(0, 3'h4);
      wr(FLG, 8'h10);
      @(posedge sys_clk);
      instr_len <= 4'h8;
      do_return();
      no_call(30);
      check("low resumed", 8'h01, {6'h00, in_service_high, in_service_low});
      // pending low after the return: one eight-cycle instruction, then the call
      do_return();
      wait_call(9, 3'h5);
      wr(FLG, 8'hFF);
      do_return();
      @(posedge sys_clk);
      run <= 1'b0;
      instr_len <= 4'h1;
      // external inputs: every pin and both polarities, unselected pins toggle too
      wr(ENA, 8'h03);
      for (int p = 0; p < 8; p++)
      begin
         pol = 1'(p);
         cfg = {pol, 3'(p), ~pol, 3'(7 - p)};
         wr(PIN, cfg);
         @(posedge sys_clk);
         port0_pins <= pol ? (8'h01 << (7 - p)) : (8'h01 << p);
         repeat (5) @(negedge sys_clk);
         wr(FLG, 8'hFF);
         @(posedge sys_clk);
         port0_pins <= ~port0_pins;
         repeat (5) @(negedge sys_clk);
         rd("pin config", PIN, cfg);
         rd("ext flags", FLG, 8'h03);
      end
      check("irq set", 8'h01, {7'h00, irq});
      wr(ENA, 8'h00);
      repeat (2) @(negedge sys_clk);
      check("irq masked", 8'h00, {7'h00, irq});
      wr(ENA, 8'h03);
      wr(FLG, 8'h03);
      repeat (2) @(negedge sys_clk);
      check("irq cleared", 8'h00, {7'h00, irq});
      end_of_test();
   end
endmodule : tb_irq_arbiter
